// ### design/dapg_pkg.sv
// shared constants and types for the debug authentication and counter gating block
package dapg_pkg;

   // implemented counters: eight event counters plus the cycle counter
   localparam int unsigned DAPG_NUM_CNT = 8;
   localparam logic [4:0] DAPG_CNT_N = 5'h08;
   // hypervisor level present; when clear the two hyp pins read as low
   localparam logic DAPG_HYP_IMPL = 1'h1;

   // register byte offsets on the apb bus
   localparam logic [11:0] DAPG_HCFG_OFF = 12'h000;
   localparam logic [11:0] DAPG_STAT_OFF = 12'h004;

   // hyp config field positions
   localparam int unsigned DAPG_HCFG_PROHIBIT = 0;
   localparam int unsigned DAPG_HCFG_UPEN = 1;
   localparam int unsigned DAPG_HCFG_EXTBLK = 2;
   localparam int unsigned DAPG_HCFG_CYCDIS = 3;
   localparam int unsigned DAPG_HCFG_DBGTRAP = 4;
   localparam int unsigned DAPG_HCFG_PART_LO = 8;
   // partition resets to the full counter count, all counters in the lower group
   localparam logic [31:0] DAPG_HCFG_RST = 32'h0000_0800;

   // status field positions
   localparam int unsigned DAPG_STAT_SELFHOST = 4;
   localparam int unsigned DAPG_STAT_SAMPLE = 5;
   localparam int unsigned DAPG_STAT_HALT = 6;
   localparam int unsigned DAPG_STAT_BLK_LO = 8;

   typedef enum logic [1:0] {
      DAPG_EL0 = 2'b00,
      DAPG_EL1 = 2'b01,
      DAPG_EL2 = 2'b10
   } dapg_el_t;

   // kinds of performance monitor access arriving from the external debugger
   typedef enum logic [2:0] {
      DAPG_EK_EVTYPE = 3'b000,
      DAPG_EK_EVCNT = 3'b001,
      DAPG_EK_BITS = 3'b010,
      DAPG_EK_CFGN = 3'b011,
      DAPG_EK_PRST = 3'b100,
      DAPG_EK_OTHER = 3'b101
   } dapg_ekind_t;

   // derived authentication enables
   typedef struct packed {
      logic hyp_noninvasive_enabled;
      logic hyp_invasive_enabled;
      logic noninvasive_enabled;
      logic invasive_enabled;
   } dapg_auth_t;

   // hypervisor counter and debug configuration
   typedef struct packed {
      logic [4:0] hyp_counter_partition;
      logic dbg_trap_en;
      logic cycle_disable_on_prohibit;
      logic external_upper_counter_block;
      logic upper_counter_hyp_enable;
      logic hyp_count_prohibit;
   } dapg_hcfg_t;

endpackage

// ### design/dapg_sync.sv
// two-stage level synchroniser for the authentication pins
`timescale 1ns/100ps
module dapg_sync #(
   parameter int unsigned W = 4
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] stage1;

   // first stage feeds only the second stage
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         stage1 <= '0;
         dout <= '0;
      end
      else
      begin
         stage1 <= din;
         dout <= stage1;
      end
   end

endmodule

// ### design/dapg_core.sv
// debug authentication derivation with self-hosted debug and counter gating
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
module dapg_core
   import dapg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic invasive_auth_in,
   input wire logic noninvasive_auth_in,
   input wire logic hyp_invasive_auth_in,
   input wire logic hyp_noninvasive_auth_in,
   input wire dapg_el_t cur_el,
   input wire logic trap_general_exceptions,
   input wire logic debug_use_req,
   input wire logic ext_req,
   input wire dapg_ekind_t ext_kind,
   input wire logic [2:0] ext_idx,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output dapg_auth_t enables,
   output logic selfhosted_debug_en,
   output logic debug_trap_hyp,
   output logic halt_allowed,
   output logic sample_prohibit,
   output logic [7:0] event_count_en,
   output logic cycle_count_en,
   output logic ext_ack,
   output logic ext_refused,
   output logic ext_raz_wi,
   output logic [8:0] ext_bits_mask,
   output logic [4:0] ext_cfg_n,
   output logic [7:0] event_reset_mask
);

   // counters whose index is at or above the partition value
   function automatic logic [7:0] upper_mask(input logic [4:0] part);
      logic [7:0] m;
      m = '0;
      for (int i = 0; i < DAPG_NUM_CNT; i++)
      begin
         m[i] = (5'(i) >= part);
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation and enable derivation

   logic [3:0] pins_q;
   logic [3:0] pins_raw;
   dapg_auth_t next_enables;
   wire logic p_inv = pins_q[0];
   wire logic p_nid = pins_q[1];
   wire logic p_hinv = pins_q[2];
   wire logic p_hnid = pins_q[3];

   assign pins_raw = {hyp_noninvasive_auth_in & DAPG_HYP_IMPL, hyp_invasive_auth_in & DAPG_HYP_IMPL,
                      noninvasive_auth_in, invasive_auth_in};

   dapg_sync #(.W(4)) u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .din(pins_raw),
      .dout(pins_q)
   );

   // recommended derivation
   // the and/or form keeps the implications below true for any pin mix
   assign next_enables.invasive_enabled = p_inv;
   assign next_enables.noninvasive_enabled = p_inv | p_nid;
   assign next_enables.hyp_invasive_enabled = p_inv & p_hinv;
   assign next_enables.hyp_noninvasive_enabled = (p_inv | p_nid) & (p_hinv | p_hnid);

   ////////////////////////////////////////////////////////////////////////////
   // apb register access

   dapg_hcfg_t hcfg;
   dapg_hcfg_t next_hcfg;
   wire logic apb_acc = psel & penable;
   wire logic hit_hcfg = (paddr[11:2] == DAPG_HCFG_OFF[11:2]);
   wire logic hit_stat = (paddr[11:2] == DAPG_STAT_OFF[11:2]);
   wire logic wr_hcfg = apb_acc & pready & pwrite & hit_hcfg;
   wire logic next_pready = apb_acc & ~pready;
   logic [31:0] hcfg_word;
   logic [31:0] stat_word;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic [7:0] ext_blk_mask;

   assign hcfg_word = {19'h00000, hcfg.hyp_counter_partition, 3'h0, hcfg.dbg_trap_en,
                       hcfg.cycle_disable_on_prohibit, hcfg.external_upper_counter_block,
                       hcfg.upper_counter_hyp_enable, hcfg.hyp_count_prohibit};
   assign stat_word = {16'h0000, ext_blk_mask, 1'h0, halt_allowed, sample_prohibit,
                       selfhosted_debug_en, enables};

   // byte lanes: low byte holds the control bits, next byte the partition
   assign next_hcfg.hyp_count_prohibit = (wr_hcfg & pstrb[0]) ? pwdata[DAPG_HCFG_PROHIBIT]
                                         : hcfg.hyp_count_prohibit;
   assign next_hcfg.upper_counter_hyp_enable = (wr_hcfg & pstrb[0]) ? pwdata[DAPG_HCFG_UPEN]
                                               : hcfg.upper_counter_hyp_enable;
   assign next_hcfg.external_upper_counter_block = (wr_hcfg & pstrb[0]) ? pwdata[DAPG_HCFG_EXTBLK]
                                                   : hcfg.external_upper_counter_block;
   assign next_hcfg.cycle_disable_on_prohibit = (wr_hcfg & pstrb[0]) ? pwdata[DAPG_HCFG_CYCDIS]
                                                : hcfg.cycle_disable_on_prohibit;
   assign next_hcfg.dbg_trap_en = (wr_hcfg & pstrb[0]) ? pwdata[DAPG_HCFG_DBGTRAP] : hcfg.dbg_trap_en;
   assign next_hcfg.hyp_counter_partition = (wr_hcfg & pstrb[1])
                                            ? pwdata[DAPG_HCFG_PART_LO +: 5] : hcfg.hyp_counter_partition;

   // read data and error are loaded one cycle into the access phase
   assign next_prdata = !next_pready ? 32'h0000_0000 : hit_hcfg ? hcfg_word
                        : hit_stat ? stat_word : 32'h0000_0000;
   assign next_pslverr = next_pready & ~(hit_hcfg | hit_stat);

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         hcfg <= dapg_hcfg_t'({DAPG_HCFG_RST[DAPG_HCFG_PART_LO +: 5], DAPG_HCFG_RST[4:0]});
         pready <= 1'h0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'h0;
      end
      else
      begin
         hcfg <= next_hcfg;
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core-side gating

   wire logic is_el2 = (cur_el == DAPG_EL2);
   wire logic hyp_ctx = is_el2 | trap_general_exceptions;
   wire logic [7:0] upper = upper_mask(hcfg.hyp_counter_partition);
   wire logic el2_prohibit = is_el2 & hcfg.hyp_count_prohibit;
   logic [7:0] next_evt_en;

   assign next_evt_en = (~upper & {8{~el2_prohibit}}) | (upper & {8{hcfg.upper_counter_hyp_enable}});

   // upper counters blocked to debugger
   // indices above the implemented count do not exist, so the mask stops at bit 7
   assign ext_blk_mask = {8{~enables.hyp_noninvasive_enabled & hcfg.external_upper_counter_block}} & upper;

   // no step exception
   // stepping is not supported, so no step state or step exception output exists
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         enables <= '0;
         selfhosted_debug_en <= 1'h0;
         debug_trap_hyp <= 1'h0;
         halt_allowed <= 1'h0;
         sample_prohibit <= 1'h1;
         event_count_en <= 8'h00;
         cycle_count_en <= 1'h0;
      end
      else
      begin
         enables <= next_enables;
         selfhosted_debug_en <= ~is_el2;
         debug_trap_hyp <= debug_use_req & hcfg.dbg_trap_en & ~is_el2;
         halt_allowed <= enables.invasive_enabled & (~hyp_ctx | enables.hyp_invasive_enabled);
         sample_prohibit <= ~enables.noninvasive_enabled | (~enables.hyp_noninvasive_enabled & hyp_ctx);
         event_count_en <= next_evt_en;
         cycle_count_en <= ~(el2_prohibit & hcfg.cycle_disable_on_prohibit);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // external debugger access filter, answered one cycle after the request

   wire logic ext_ok = ext_req & enables.noninvasive_enabled;
   wire logic ext_reg_kind = (ext_kind == DAPG_EK_EVTYPE) | (ext_kind == DAPG_EK_EVCNT);

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         ext_ack <= 1'h0;
         ext_refused <= 1'h0;
         ext_raz_wi <= 1'h0;
         ext_bits_mask <= 9'h000;
         ext_cfg_n <= DAPG_CNT_N;
         event_reset_mask <= 8'h00;
      end
      else
      begin
         ext_ack <= ext_req;
         ext_refused <= ext_req & ~enables.noninvasive_enabled;
         ext_raz_wi <= ext_ok & ext_reg_kind & ext_blk_mask[ext_idx];
         ext_bits_mask <= (ext_ok & (ext_kind == DAPG_EK_BITS)) ? {1'h1, ~ext_blk_mask} : 9'h000;
         ext_cfg_n <= hcfg.external_upper_counter_block ? hcfg.hyp_counter_partition : DAPG_CNT_N;
         event_reset_mask <= (ext_ok & (ext_kind == DAPG_EK_PRST)) ? ~ext_blk_mask : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_selfhost_el2_off: assert property (
      is_el2 |=> !selfhosted_debug_en) else $error("self-hosted debug on at EL2");
   a_selfhost_low_on: assert property (
      !is_el2 |=> selfhosted_debug_en) else $error("self-hosted debug off at EL1 or EL0");
   a_debug_trap_pulse: assert property (
      debug_use_req && hcfg.dbg_trap_en && !is_el2 |=> debug_trap_hyp ##1 $past(debug_use_req) || !debug_trap_hyp)
      else $error("debug use not trapped");
   a_lower_cnt_stop: assert property (
      el2_prohibit |=> (event_count_en & ~$past(upper)) == 8'h00) else $error("lower counter runs");
   a_cycle_cnt_stop: assert property (
      el2_prohibit && hcfg.cycle_disable_on_prohibit |=> !cycle_count_en) else $error("cycle counter runs");
   a_upper_cnt_en: assert property (
      1'b1 |=> (event_count_en & $past(upper)) == ($past(upper) & {8{$past(hcfg.upper_counter_hyp_enable)}}))
      else $error("upper counter enable wrong");
   a_blocked_raz: assert property (
      ext_req && enables.noninvasive_enabled && ext_reg_kind && ext_blk_mask[ext_idx] |=> ext_raz_wi && ext_ack)
      else $error("blocked counter register reachable");
   a_reset_spares: assert property (
      ext_req && ext_kind == DAPG_EK_PRST |=> (event_reset_mask & $past(ext_blk_mask)) == 8'h00)
      else $error("blocked counter reset");
   a_cfg_n_view: assert property (
      hcfg.external_upper_counter_block |=> ext_cfg_n == $past(hcfg.hyp_counter_partition))
      else $error("counter count view wrong");
   a_sample_block: assert property (
      !enables.hyp_noninvasive_enabled && hyp_ctx |=> sample_prohibit) else $error("sampling allowed");
   a_ext_refuse: assert property (
      ext_req && !enables.noninvasive_enabled |=> ext_refused && !ext_raz_wi && ext_bits_mask == 9'h000)
      else $error("debugger access not refused");
   a_enable_order: assert property (
      (enables.invasive_enabled || !enables.hyp_invasive_enabled)
      && (enables.noninvasive_enabled || !enables.hyp_noninvasive_enabled)) else $error("enable order broken");
   a_enable_derive: assert property (
      ##1 enables.noninvasive_enabled == $past(p_inv | p_nid)
      && enables.hyp_invasive_enabled == $past(p_inv & p_hinv)) else $error("enable derivation wrong");
   a_apb_answer: assert property (
      psel && penable && !pready |=> pready ##1 !pready) else $error("apb answer timing wrong");

   // implication between the derived enables, the other half of the pair above
   a_enable_imply: assert property (
      (!enables.invasive_enabled || enables.noninvasive_enabled)
      && (!enables.hyp_invasive_enabled || enables.hyp_noninvasive_enabled))
      else $error("enable implication broken");

   // the pins reach the derivation exactly two edges after they are sampled
   a_sync_delay: assert property (
      ##2 pins_q == $past(pins_raw, 2)) else $error("pin synchroniser delay wrong");

   // halting needs invasive debug, and hyp invasive debug in a hyp context; sampling needs non-invasive debug
   a_halt_inv: assert property (
      !enables.invasive_enabled |=> !halt_allowed) else $error("halt allowed without invasive debug");
   a_halt_hyp: assert property (
      !enables.hyp_invasive_enabled && hyp_ctx |=> !halt_allowed) else $error("halt allowed in hyp context");
   a_sample_noninv: assert property (
      !enables.noninvasive_enabled |=> sample_prohibit) else $error("sampling allowed without non-invasive debug");

   // a trap is only raised from the lower levels
   a_trap_el2_quiet: assert property (
      is_el2 |=> !debug_trap_hyp) else $error("debug trap raised at EL2");

   // the cycle counter keeps running unless the prohibit applies at EL2 with the cycle disable bit set
   a_cycle_cnt_run: assert property (
      !el2_prohibit |=> cycle_count_en) else $error("cycle counter stopped");

   // the debugger sees the full counter count while the upper block is clear
   a_cfg_n_full: assert property (
      !hcfg.external_upper_counter_block |=> ext_cfg_n == DAPG_CNT_N)
      else $error("full counter count not shown");

   // overflow and enable bits of upper counters stay hidden without hyp non-invasive debug while the upper block is set
   a_upper_bits_hidden: assert property (
      ext_req && enables.noninvasive_enabled && !enables.hyp_noninvasive_enabled
      && hcfg.external_upper_counter_block && ext_kind == DAPG_EK_BITS
      |=> (ext_bits_mask[7:0] & $past(upper)) == 8'h00 && ext_bits_mask[8])
      else $error("upper counter bits visible");

   // debugger answers other than ext_cfg_n follow each request cycle one cycle later and nothing else
   a_ext_answer: assert property (
      ext_req |=> ext_ack) else $error("debugger request not answered");
   a_ext_quiet: assert property (
      !ext_req |=> !ext_ack && !ext_refused && !ext_raz_wi && ext_bits_mask == 9'h000 && event_reset_mask == 8'h00)
      else $error("debugger answer without request");
   a_ext_grant: assert property (
      ext_req && enables.noninvasive_enabled |=> !ext_refused) else $error("permitted debugger access refused");
   a_raz_open: assert property (
      ext_req && ext_reg_kind && !ext_blk_mask[ext_idx] |=> !ext_raz_wi) else $error("open counter register hidden");

   // bus outputs fall back to zero between transfers, and a partition write lands at the pready edge
   a_apb_idle: assert property (
      !(psel && penable) |=> !pready && !pslverr && prdata == 32'h0000_0000) else $error("apb outputs not idle");
   a_part_write: assert property (
      psel && penable && pready && pwrite && hit_hcfg && pstrb[1]
      |=> hcfg.hyp_counter_partition == $past(pwdata[DAPG_HCFG_PART_LO +: 5])) else $error("partition write lost");

endmodule

// ### verification/dapg_dbg_model.sv
// debugger and authentication pin model on the far side of the gating block
`timescale 1ns/100ps
module dapg_dbg_model
   import dapg_pkg::*;
(
   input wire logic clk_sys,
   output logic [3:0] auth_pins,
   output logic ext_req,
   output dapg_ekind_t ext_kind,
   output logic [2:0] ext_idx
);
   // pins low and no request at time zero
   initial
   begin
      auth_pins = 4'h0;
      ext_req = 1'b0;
      ext_kind = DAPG_EK_OTHER;
      ext_idx = 3'h0;
   end
   // one pin set
   // a trace unit would take this same set
   task set_pins(input logic [3:0] p);
      @(posedge clk_sys);
      auth_pins <= p;
   endtask
   // one request cycle; qualifiers are scrambled after it so stale values never pass
   task access(input dapg_ekind_t k, input logic [2:0] i);
      @(posedge clk_sys);
      ext_req <= 1'b1;
      ext_kind <= k;
      ext_idx <= i;
      @(posedge clk_sys);
      ext_req <= 1'b0;
      ext_kind <= dapg_ekind_t'(~k);
      ext_idx <= ~i;
   endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench for the debug authentication and counter gating block
`timescale 1ns/100ps
module tb_top;
   import dapg_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   dapg_el_t cur_el = DAPG_EL1;
   logic trap_general_exceptions = 1'b0;
   logic debug_use_req = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [3:0] auth_pins;
   logic ext_req;
   dapg_ekind_t ext_kind;
   logic [2:0] ext_idx;
   logic [31:0] prdata;
   logic pready, pslverr, selfhosted_debug_en, debug_trap_hyp, halt_allowed, sample_prohibit;
   logic cycle_count_en, ext_ack, ext_refused, ext_raz_wi;
   dapg_auth_t enables;
   logic [7:0] event_count_en;
   logic [7:0] event_reset_mask;
   logic [8:0] ext_bits_mask;
   logic [4:0] ext_cfg_n;
   logic [31:0] rdv;
   logic erv;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   dapg_dbg_model i_dbg (.clk_sys(clk_sys), .auth_pins(auth_pins), .ext_req(ext_req),
      .ext_kind(ext_kind), .ext_idx(ext_idx));
   dapg_core i_dut (.clk_sys(clk_sys), .nrst(nrst), .invasive_auth_in(auth_pins[0]),
      .noninvasive_auth_in(auth_pins[1]), .hyp_invasive_auth_in(auth_pins[2]),
      .hyp_noninvasive_auth_in(auth_pins[3]), .cur_el(cur_el),
      .trap_general_exceptions(trap_general_exceptions), .debug_use_req(debug_use_req),
      .ext_req(ext_req), .ext_kind(ext_kind), .ext_idx(ext_idx), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .enables(enables), .selfhosted_debug_en(selfhosted_debug_en),
      .debug_trap_hyp(debug_trap_hyp), .halt_allowed(halt_allowed), .sample_prohibit(sample_prohibit),
      .event_count_en(event_count_en), .cycle_count_en(cycle_count_en), .ext_ack(ext_ack),
      .ext_refused(ext_refused), .ext_raz_wi(ext_raz_wi), .ext_bits_mask(ext_bits_mask),
      .ext_cfg_n(ext_cfg_n), .event_reset_mask(event_reset_mask));

   // 40 MHz core clock
   always #12.5 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////
   task wrap_up;
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // hang guard: the whole run needs well under this many cycles
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         num_errors++;
         wrap_up;
      end
   end
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // apb master: waits on pready with no cycle count assumed
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // outputs trail inputs by one cycle; enables trail pins by three, halt and sampling by four
   task settle;
      repeat (5) @(posedge clk_sys);
   endtask
   task ext(input dapg_ekind_t k, input logic [2:0] i);
      i_dbg.access(k, i);
      @(posedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////
   // all sixteen pin patterns against the and/or derivation
   task t_auth;
      logic [3:0] p;
      for (int n = 0; n < 16; n++)
      begin
         p = 4'(n);
         i_dbg.set_pins(p);
         settle;
         chk("enables", {28'h0, (p[0] | p[1]) & (p[2] | p[3]), p[0] & p[2], p[0] | p[1], p[0]},
            32'(enables));
         chk("halt_allowed", 32'(p[0]), 32'(halt_allowed));
      end
   endtask
   task t_selfhost;
      for (int e = 0; e < 3; e++)
      begin
         cur_el <= dapg_el_t'(e);
         settle;
         chk("selfhosted_debug_en", 32'(e != 2), 32'(selfhosted_debug_en));
      end
   endtask
   // attempted debug use at EL1, trap armed or not
   task t_trap(input logic [31:0] cfg, input logic exp);
      apb(1'b1, DAPG_HCFG_OFF, cfg, 4'hF);
      cur_el <= DAPG_EL1;
      settle;
      debug_use_req <= 1'b1;
      @(posedge clk_sys);
      debug_use_req <= 1'b0;
      @(posedge clk_sys);
      chk("debug_trap_hyp", 32'(exp), 32'(debug_trap_hyp));
      @(posedge clk_sys);
      chk("debug_trap_hyp end", 32'h0, 32'(debug_trap_hyp));
   endtask
   task t_count(input logic [31:0] cfg, input dapg_el_t el, input logic [7:0] ev, input logic cy);
      apb(1'b1, DAPG_HCFG_OFF, cfg, 4'hF);
      cur_el <= el;
      settle;
      chk("event_count_en", 32'(ev), 32'(event_count_en));
      chk("cycle_count_en", 32'(cy), 32'(cycle_count_en));
   endtask
   // upper block with partition 4 while hyp non-invasive is off
   task t_extblk;
      i_dbg.set_pins(4'h2);
      apb(1'b1, DAPG_HCFG_OFF, 32'h0000_0404, 4'hF);
      cur_el <= DAPG_EL2;
      settle;
      chk("sample_prohibit el2", 32'h1, 32'(sample_prohibit));
      ext(DAPG_EK_EVCNT, 3'h5);
      chk("ext_ack", 32'h1, 32'(ext_ack));
      chk("ext_raz_wi upper", 32'h1, 32'(ext_raz_wi));
      ext(DAPG_EK_EVTYPE, 3'h3);
      chk("ext_raz_wi lower", 32'h0, 32'(ext_raz_wi));
      ext(DAPG_EK_PRST, 3'h0);
      chk("event_reset_mask", 32'h0F, 32'(event_reset_mask));
      ext(DAPG_EK_CFGN, 3'h0);
      chk("ext_cfg_n", 32'h4, 32'(ext_cfg_n));
      ext(DAPG_EK_BITS, 3'h0);
      chk("ext_bits_mask", 32'h0000_010F, 32'(ext_bits_mask));
      cur_el <= DAPG_EL1;
      settle;
      chk("sample_prohibit el1", 32'h0, 32'(sample_prohibit));
      trap_general_exceptions <= 1'b1;
      settle;
      chk("sample_prohibit trap", 32'h1, 32'(sample_prohibit));
      trap_general_exceptions <= 1'b0;
      i_dbg.set_pins(4'hF);
      settle;
      ext(DAPG_EK_EVCNT, 3'h5);
      chk("ext_raz_wi allowed", 32'h0, 32'(ext_raz_wi));
      i_dbg.set_pins(4'h0);
      settle;
      ext(DAPG_EK_EVCNT, 3'h0);
      chk("ext_refused", 32'h1, 32'(ext_refused));
      chk("ext_raz_wi refused", 32'h0, 32'(ext_raz_wi));
   endtask
   // register reset value, lane strobes, read-only status and a hole in the map
   task t_apb;
      apb(1'b0, DAPG_HCFG_OFF, 32'h0, 4'hF);
      chk("hcfg reset", DAPG_HCFG_RST, rdv);
      apb(1'b1, DAPG_HCFG_OFF, 32'h0000_0305, 4'h1);
      apb(1'b0, DAPG_HCFG_OFF, 32'h0, 4'hF);
      chk("hcfg lane0", 32'h0000_0805, rdv);
      apb(1'b1, DAPG_HCFG_OFF, DAPG_HCFG_RST, 4'hF);
      apb(1'b1, DAPG_STAT_OFF, 32'hFFFF_FFFF, 4'hF);
      chk("status write err", 32'h0, 32'(erv));
      i_dbg.set_pins(4'hF);
      settle;
      apb(1'b0, DAPG_STAT_OFF, 32'h0, 4'hF);
      chk("status", 32'h0000_005F, rdv);
      apb(1'b0, 12'h008, 32'h0, 4'hF);
      chk("unmapped err", 32'h1, 32'(erv));
      chk("unmapped data", 32'h0, rdv);
   endtask

   ////////////////////////////////////////////////////////////
   // reset held 16 cycles, then flushed through the synchroniser
   initial
   begin
      repeat (16) @(posedge clk_sys);
      chk("sample_prohibit reset", 32'h1, 32'(sample_prohibit));
      chk("ext_cfg_n reset", 32'h8, 32'(ext_cfg_n));
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_apb;
      t_auth;
      t_selfhost;
      t_trap(32'h0000_0810, 1'b1);
      t_trap(32'h0000_0800, 1'b0);
      t_count(32'h0000_0409, DAPG_EL2, 8'h00, 1'b0);
      t_count(32'h0000_040B, DAPG_EL2, 8'hF0, 1'b0);
      t_count(32'h0000_040B, DAPG_EL1, 8'hFF, 1'b1);
      t_count(32'h0000_0403, DAPG_EL2, 8'hF0, 1'b1);
      t_extblk;
      wrap_up;
   end
endmodule
